/* core/antenna_diversity_map.svh */
// Constants for the antenna diversity controller
`ifndef ANTENNA_DIVERSITY_MAP_SVH
`define ANTENNA_DIVERSITY_MAP_SVH
`define DIV_MODE_OFF 3'h0
`define DIV_MODE_AUTO 3'h1
`define DIV_MODE_FIXED_A 3'h2
`define DIV_MODE_FIXED_B 3'h3
`define DIV_DWELL_DEFAULT 16'h0040
`define DIV_DWELL_NS 2560
`define DIV_CLK_NS 40
`endif

/* core/antenna_diversity_pkg.sv */
// Types for the antenna diversity controller
package antenna_diversity_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TOGGLE = 3'b001,
    ST_MEAS_A = 3'b010,
    ST_MEAS_B = 3'b011,
    ST_HOLD = 3'b100
  } div_state_t;
  typedef logic [1:0] pin_pair_t;
endpackage

/* core/switch_pin_map.sv */
// Maps the chosen antenna onto the switch control pins
`timescale 1ns/1ps
`default_nettype none
module switch_pin_map
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ant_sel,
  input wire logic active,
  input wire logic [1:0] pin_invert,
  input wire logic single_ended,
  output logic [1:0] general_purpose_pins
);
  logic [1:0] pins_next;
  logic [1:0] pins_reg;
  wire [1:0] raw_pins = single_ended ? {1'b0, ant_sel} : {ant_sel, ~ant_sel};
  // Idle switch sits with both pins low before polarity is applied
  assign pins_next = (active ? raw_pins : 2'b00) ^ pin_invert;
  always_ff @(posedge clk)
  begin
    if (rst)
      pins_reg <= 2'h0;
    else
      pins_reg <= pins_next;
  end
  assign general_purpose_pins = pins_reg;
endmodule // switch_pin_map
`default_nettype wire

/* core/antenna_diversity_control.sv */
// Antenna diversity controller: dwell, compare and hold of two antennas
`include "antenna_diversity_map.svh"
`timescale 1ns/1ps
`default_nettype none
module antenna_diversity_control
#(
  parameter int RSSI_W = 8,
  parameter int DWELL_W = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] modem_diversity_config_property,
  input wire logic [1:0] pin_invert,
  input wire logic single_ended,
  input wire logic [DWELL_W-1:0] dwell_cycles,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic preamble_det,
  input wire logic sync_det,
  input wire logic packet_end,
  input wire logic rssi_valid,
  input wire logic [RSSI_W-1:0] rssi,
  output logic ant_sel,
  output logic decision_done,
  output antenna_diversity_pkg::pin_pair_t general_purpose_pins
);
  import antenna_diversity_pkg::*;

  // The dwell counter must be wide enough to hold the default stay
  if (RSSI_W < 1 || DWELL_W < $clog2(`DIV_DWELL_DEFAULT + 1))
  begin : g_bad_widths
    $error("antenna_diversity_control: bad widths");
  end

  div_state_t state_reg, state_next;
  logic ant_reg, ant_next;
  logic [DWELL_W-1:0] dwell_reg, dwell_next;
  logic [RSSI_W-1:0] rssi_a_reg, rssi_a_next;
  logic done_reg, done_next;

  // No synchronisers: every status input is launched by logic on clk,
  // so a source from a pin must be synchronised outside this block.
  wire auto_mode = modem_diversity_config_property == `DIV_MODE_AUTO;
  wire fix_a = modem_diversity_config_property == `DIV_MODE_FIXED_A;
  wire fix_b = modem_diversity_config_property == `DIV_MODE_FIXED_B;
  wire dwell_over = dwell_reg == '0;
  wire [DWELL_W-1:0] dwell_load = (dwell_cycles == '0) ?
    DWELL_W'(`DIV_DWELL_DEFAULT) : dwell_cycles;
  // Ties keep the antenna already in use to avoid a needless switch
  wire a_stronger = rssi < rssi_a_reg;

  always_comb
  begin
    state_next = state_reg;
    ant_next = ant_reg;
    dwell_next = dwell_over ? '0 : dwell_reg - 1'b1;
    rssi_a_next = rssi_a_reg;
    done_next = 1'b0;
    if (fix_a)
      ant_next = 1'b0;
    else if (fix_b)
      ant_next = 1'b1;
    case (state_reg)
      ST_IDLE:
      begin
        if (auto_mode && rx_on && !tx_on)
        begin
          state_next = ST_TOGGLE;
          dwell_next = dwell_load;
        end
      end
      ST_TOGGLE:
      begin
        if (!rx_on || !auto_mode)
          state_next = ST_IDLE;
        else if (preamble_det)
        begin
          state_next = ST_MEAS_A;
          ant_next = 1'b0;
        end
        else if (dwell_over)
        begin
          ant_next = ~ant_reg;
          dwell_next = dwell_load;
        end
      end
      ST_MEAS_A:
      begin
        if (!rx_on || !auto_mode)
          state_next = ST_IDLE;
        else if (rssi_valid)
        begin
          rssi_a_next = rssi;
          ant_next = 1'b1;
          state_next = ST_MEAS_B;
        end
        else if (sync_det)
        begin
          // Preamble ended early: keep antenna A rather than guess
          state_next = ST_HOLD;
          done_next = 1'b1;
        end
      end
      ST_MEAS_B:
      begin
        if (!rx_on || !auto_mode)
          state_next = ST_IDLE;
        else if (rssi_valid || sync_det)
        begin
          // B is on the switch now; move back to A if A was stronger or sync came before B was measured
          if (rssi_valid && a_stronger)
            ant_next = 1'b0;
          else if (sync_det && !rssi_valid)
            ant_next = 1'b0;
          state_next = ST_HOLD;
          done_next = 1'b1;
        end
      end
      ST_HOLD:
      begin
        // Antenna frozen to the end of the packet and into the next TX
        if (packet_end || !rx_on)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      ant_reg <= 1'b0;
      dwell_reg <= '0;
      rssi_a_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ant_reg <= ant_next;
      dwell_reg <= dwell_next;
      rssi_a_reg <= rssi_a_next;
      done_reg <= done_next;
    end
  end

  assign ant_sel = ant_reg;
  assign decision_done = done_reg;

  wire pins_active = modem_diversity_config_property != `DIV_MODE_OFF;

  switch_pin_map u_pins
  (
    .clk(clk),
    .rst(rst),
    .ant_sel(ant_reg),
    .active(pins_active),
    .pin_invert(pin_invert),
    .single_ended(single_ended),
    .general_purpose_pins(general_purpose_pins)
  );

  AST_ENTRY_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_IDLE && auto_mode && rx_on && !tx_on
    |=> state_reg == ST_TOGGLE)
    else $error("RX entry did not start diversity");
  AST_MEAS_ON_PREAMBLE: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_TOGGLE && rx_on && auto_mode && preamble_det
    |=> state_reg == ST_MEAS_A && !ant_reg)
    else $error("Preamble did not start measurement on A");
  AST_PICK_A: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_MEAS_B && rx_on && auto_mode && rssi_valid
    && rssi < rssi_a_reg |=> !ant_reg && state_reg == ST_HOLD)
    else $error("Stronger antenna A not chosen");
  AST_TIE_KEEPS: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_MEAS_B && rx_on && auto_mode && rssi_valid
    && rssi == rssi_a_reg |=> ant_reg)
    else $error("Tie switched antenna");
  AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_HOLD && auto_mode |=> $stable(ant_reg))
    else $error("Antenna changed during packet");
  AST_TX_KEEPS: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_IDLE && auto_mode && tx_on |=> $stable(ant_reg))
    else $error("Antenna changed for transmit");
  AST_TOGGLE: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_TOGGLE && rx_on && auto_mode && !preamble_det
    && dwell_over |=> ant_reg != $past(ant_reg))
    else $error("No alternation at dwell end");
  AST_PINS: assert property (@(posedge clk) disable iff (rst)
    pins_active && !single_ended |=>
    general_purpose_pins == ({$past(ant_reg), ~$past(ant_reg)}
    ^ $past(pin_invert)))
    else $error("Switch pins disagree with antenna");
  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (rst)
    modem_diversity_config_property == `DIV_MODE_OFF
    && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("Diversity ran while disabled");
  AST_SYNC_KEEPS_A: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_MEAS_A && rx_on && auto_mode && !rssi_valid && sync_det
    |=> state_reg == ST_HOLD && !ant_reg && decision_done)
    else $error("Early sync did not hold antenna A");

  COV_DECIDE: cover property (@(posedge clk) decision_done);
  COV_PICK_B: cover property (@(posedge clk)
    state_reg == ST_MEAS_B ##1 state_reg == ST_HOLD && ant_reg);
  COV_TOGGLE: cover property (@(posedge clk)
    state_reg == ST_TOGGLE && dwell_over && !preamble_det);
endmodule // antenna_diversity_control
`default_nettype wire

/* sim/rf_switch_model.sv */
// Two-antenna RF switch returning the strength on the linked path
`timescale 1ns/1ps
`default_nettype none
module rf_switch_model
(
  input wire logic [1:0] general_purpose_pins,
  input wire logic [7:0] level_a,
  input wire logic [7:0] level_b,
  output logic [7:0] rssi
);
  // Both or neither throw gives no path, so no signal reaches the receiver
  assign rssi = (general_purpose_pins == 2'b01) ? level_a :
    (general_purpose_pins == 2'b10) ? level_b : 8'h00;
endmodule // rf_switch_model
`default_nettype wire

/* sim/antenna_diversity_control_tb.sv */
// Self-checking bench for the antenna diversity controller
`include "antenna_diversity_map.svh"
`timescale 1ns/1ps
`default_nettype none
module antenna_diversity_control_tb;
  import antenna_diversity_pkg::*;
  logic clk = 1'b0, rst = 1'b1, se = 1'b0, rx = 1'b0, tx = 1'b0;
  logic pre = 1'b0, sync = 1'b0, pend = 1'b0, rv = 1'b0;
  logic [2:0] mode = 3'h1;
  logic [1:0] inv = 2'h0;
  logic [15:0] dwell = 16'h0003;
  logic [7:0] la = 8'h00, lb = 8'h00, rssi;
  logic ant, done;
  pin_pair_t pins;
  logic [16:0] rows [4] = '{{8'h0a, 8'h05, 1'b0}, {8'h05, 8'h0a, 1'b1},
    {8'hff, 8'h00, 1'b0}, {8'h07, 8'h07, 1'b1}};
  int failures = 0, n_checks = 0, i, k;
  logic last;
  always #20 clk = ~clk;
  antenna_diversity_control uut (.clk(clk), .rst(rst),
    .modem_diversity_config_property(mode), .pin_invert(inv),
    .single_ended(se), .dwell_cycles(dwell), .rx_on(rx), .tx_on(tx),
    .preamble_det(pre), .sync_det(sync), .packet_end(pend),
    .rssi_valid(rv), .rssi(rssi), .ant_sel(ant), .decision_done(done),
    .general_purpose_pins(pins));
  rf_switch_model sw (.general_purpose_pins(pins), .level_a(la),
    .level_b(lb), .rssi(rssi));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      n_checks++;
      if (got !== exp)
      begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Preamble starts the window; each antenna is sampled once it settles
  task start_rx(input logic [7:0] a, input logic [7:0] b);
    begin
      la = a;
      lb = b;
      rx = 1'b1;
      tx = 1'b0;
      cyc(2);
      pre = 1'b1;
      cyc(1);
      pre = 1'b0;
      cyc(3);
    end
  endtask
  task pulse_rv;
    begin
      rv = 1'b1;
      cyc(1);
      rv = 1'b0;
    end
  endtask
  task end_rx;
    begin
      pend = 1'b1;
      cyc(1);
      pend = 1'b0;
      rx = 1'b0;
      tx = 1'b1;
      cyc(3);
    end
  endtask
  initial
  begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    cyc(6);
    chk({ant, done, pins}, 4'h0);
    rst = 1'b0;
    for (i = 0; i < 4; i++)
    begin
      start_rx(rows[i][16:9], rows[i][8:1]);
      pulse_rv;
      cyc(3);
      pulse_rv;
      for (k = 0; k < 4 && done !== 1'b1; k++)
        cyc(1);
      chk(done, 1'b1);
      chk(ant, rows[i][0]);
      cyc(1);
      chk(pins, {rows[i][0], ~rows[i][0]});
      pulse_rv;
      chk(ant, rows[i][0]);
      end_rx;
      chk(ant, rows[i][0]);
    end
    // Sync word while still on the first antenna ends the window there
    start_rx(8'h01, 8'hf0);
    sync = 1'b1;
    cyc(1);
    sync = 1'b0;
    cyc(2);
    pulse_rv;
    cyc(3);
    pulse_rv;
    cyc(2);
    chk(ant, 1'b0);
    end_rx;
    rx = 1'b1;
    tx = 1'b0;
    cyc(3);
    k = 0;
    last = ant;
    repeat (8)
    begin
      cyc(1);
      k += (ant !== last);
      last = ant;
    end
    chk(8'(k), 8'h02);
    // Reset in mid-packet drops back to antenna A, then a clean start
    rx = 1'b0;
    cyc(2);
    start_rx(8'h05, 8'h0a);
    pulse_rv;
    cyc(2);
    chk(ant, 1'b1);
    rst = 1'b1;
    cyc(2);
    chk({ant, done, pins}, 4'h0);
    rst = 1'b0;
    cyc(1);
    chk(pins, 2'b01);
    pre = 1'b1;
    cyc(1);
    pre = 1'b0;
    cyc(3);
    pulse_rv;
    cyc(3);
    pulse_rv;
    chk(done, 1'b1);
    chk(ant, 1'b1);
    end_rx;
    // Zero dwell selects the default stay on each antenna
    dwell = 16'h0000;
    rx = 1'b1;
    tx = 1'b0;
    k = 0;
    last = ant;
    while (ant === last && k < 200)
    begin
      cyc(1);
      k++;
    end
    chk(8'(k), 8'(`DIV_DWELL_DEFAULT + 2));
    rx = 1'b0;
    mode = 3'h3;
    cyc(2);
    chk(ant, 1'b1);
    mode = 3'h2;
    cyc(2);
    chk(ant, 1'b0);
    se = 1'b1;
    mode = 3'h3;
    cyc(3);
    chk(pins, 2'b01);
    mode = 3'h0;
    inv = 2'h3;
    cyc(3);
    chk(pins, 2'b11);
    report_and_stop;
  end
endmodule // antenna_diversity_control_tb
`default_nettype wire
